// ==== include/crf_pkg.sv ====
// crf_pkg: constants, types and carriers of the cpu register file
// assumes one core clock; execution unit and software bus share it
//
// Functional notes
// - four 16-bit data registers readable and writable as operands
// - first two data registers also accessed as separate upper and lower bytes
// - third:first and fourth:second data registers pair into 32-bit operands
// - two 16-bit address registers, used as addressing base and operands
// - address registers pair into 32 bits, second one upper
// - 16-bit frame base pointer for frame-relative addressing
// - 20-bit vector table base holds interrupt vector table start
// - 20-bit next instruction address register
// - separate 16-bit user and interrupt stack pointers
// - stack-select flag picks user or interrupt pointer as active
// - 16-bit static base pointer for static-base-relative addressing
// - flag word is an 11-bit register showing processor state
// - carry flag captures alu carry, borrow or shifted-out bit
// - zero flag set when result is zero, else cleared
// - sign flag set when result is negative, else cleared
// - bank-select flag picks register bank 0 or 1
// - overflow flag set on overflow, else cleared
package crf_pkg;

  // ----------------------------------------------------------------
  // software register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_DATA0  = 5'h00;
  localparam logic [4:0] IDX_DATA1  = 5'h01;
  localparam logic [4:0] IDX_DATA2  = 5'h02;
  localparam logic [4:0] IDX_DATA3  = 5'h03;
  localparam logic [4:0] IDX_ADDR0  = 5'h04;
  localparam logic [4:0] IDX_ADDR1  = 5'h05;
  localparam logic [4:0] IDX_FRAME  = 5'h06;
  localparam logic [4:0] IDX_VECTB  = 5'h07;
  localparam logic [4:0] IDX_NEXTPC = 5'h08;
  localparam logic [4:0] IDX_USTACK = 5'h09;
  localparam logic [4:0] IDX_ISTACK = 5'h0a;
  localparam logic [4:0] IDX_STATIC = 5'h0b;
  localparam logic [4:0] IDX_FLAGS  = 5'h0c;

  // ----------------------------------------------------------------
  // flag word layout
  // ----------------------------------------------------------------
  localparam int FLG_W   = 11;
  localparam int FLG_C   = 0;
  localparam int FLG_D   = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_S   = 3;
  localparam int FLG_B   = 4;
  localparam int FLG_O   = 5;
  localparam int FLG_I   = 6;
  localparam int FLG_U   = 7;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  localparam int ADR_W  = 20;
  localparam logic [WORD_W-1:0] RST_WORD  = 16'h0000;
  localparam logic [ADR_W-1:0]  RST_ADR   = 20'h00000;
  localparam logic [FLG_W-1:0]  RST_FLAGS = 11'h000;

  // operand selectors seen by the execution unit
  typedef enum logic [3:0] {
    OPD_DATA0, OPD_DATA1, OPD_DATA2, OPD_DATA3,
    OPD_D0_LO, OPD_D0_HI, OPD_D1_LO, OPD_D1_HI,
    OPD_PAIR_LOW, OPD_PAIR_HIGH,
    OPD_ADDR0, OPD_ADDR1, OPD_ADDR_PAIR,
    OPD_FRAME, OPD_STATIC, OPD_STACK
  } crf_opnd_t;

  typedef enum logic [1:0] {WID_BYTE, WID_WORD, WID_LONG} crf_width_t;

  // operand read request
  typedef struct packed {
    logic      valid;
    crf_opnd_t sel;
  } crf_rd_req_t;

  // operand write-back
  typedef struct packed {
    logic              valid;
    crf_opnd_t         sel;
    logic [LONG_W-1:0] data;
  } crf_wb_t;

  // alu flag update
  typedef struct packed {
    logic              valid;
    crf_width_t        width;
    logic [LONG_W-1:0] result;
    logic              carry;
    logic              ovf;
  } crf_flag_upd_t;

  // next instruction address load
  typedef struct packed {
    logic             load;
    logic [ADR_W-1:0] addr;
  } crf_pc_ld_t;

  // addressing bases toward the address unit
  typedef struct packed {
    logic [WORD_W-1:0] addr0;
    logic [WORD_W-1:0] addr1;
    logic [WORD_W-1:0] frame;
    logic [WORD_W-1:0] stat;
    logic [WORD_W-1:0] stack;
    logic [ADR_W-1:0]  vectb;
    logic [ADR_W-1:0]  pc;
  } crf_ptrs_t;

endpackage

// ==== rtl/crf_regfile.sv ====
// crf_regfile: banked cpu register file with flag word
// assumes exec unit and software port are synchronous to mclk_in
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module crf_regfile (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_b_in,
  // software register port
  input  wire logic [4:0]             sw_addr_in,
  input  wire logic [31:0]            sw_wdata_in,
  input  wire logic                   sw_wr_in,
  input  wire logic                   sw_rd_in,
  output logic      [31:0]            sw_rdata_out,
  // execution unit
  input  crf_pkg::crf_rd_req_t        rd_req_in,
  output logic      [31:0]            rd_data_out,
  input  crf_pkg::crf_wb_t            wb_in,
  input  crf_pkg::crf_flag_upd_t      flag_upd_in,
  input  crf_pkg::crf_pc_ld_t         pc_ld_in,
  output crf_pkg::crf_ptrs_t          ptrs_out,
  output logic      [10:0]            flags_out
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] data_r [2][4];
  logic [WORD_W-1:0] addr_r [2][2];
  logic [WORD_W-1:0] frame_r [2];
  logic [WORD_W-1:0] data_nxt [2][4];
  logic [WORD_W-1:0] addr_nxt [2][2];
  logic [WORD_W-1:0] frame_nxt [2];
  logic [ADR_W-1:0]  vectb_r, vectb_nxt;
  logic [ADR_W-1:0]  pc_r, pc_nxt;
  logic [WORD_W-1:0] ustack_r, ustack_nxt;
  logic [WORD_W-1:0] istack_r, istack_nxt;
  logic [WORD_W-1:0] static_r, static_nxt;
  logic [FLG_W-1:0]  flags_r, flags_nxt;
  logic [31:0]       sw_rdata_r, sw_rdata_nxt;
  logic [31:0]       rd_data_r, rd_data_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // operand masked to width, for zero test
  function automatic logic [31:0] width_mask(input crf_width_t w, input logic [31:0] v);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (w)
      WID_BYTE: m = {24'h00_0000, v[7:0]};
      WID_WORD: m = {16'h0000, v[15:0]};
      default:  m = v;
    endcase
    return m;
  endfunction

  // sign bit at operand width
  function automatic logic width_sign(input crf_width_t w, input logic [31:0] v);
    logic s;
    s = 1'b0;
    case (w)
      WID_BYTE: s = v[7];
      WID_WORD: s = v[15];
      default:  s = v[31];
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // bank and stack selection
  // ----------------------------------------------------------------
  wire logic              bank_sel  = flags_r[FLG_B];
  wire logic              ustk_sel  = flags_r[FLG_U];
  wire logic [WORD_W-1:0] stack_act = ustk_sel ? ustack_r : istack_r;
  wire logic [WORD_W-1:0] d0 = data_r[bank_sel][0];
  wire logic [WORD_W-1:0] d1 = data_r[bank_sel][1];
  wire logic [WORD_W-1:0] d2 = data_r[bank_sel][2];
  wire logic [WORD_W-1:0] d3 = data_r[bank_sel][3];
  wire logic [WORD_W-1:0] a0 = addr_r[bank_sel][0];
  wire logic [WORD_W-1:0] a1 = addr_r[bank_sel][1];
  wire logic [WORD_W-1:0] fb = frame_r[bank_sel];

  // ----------------------------------------------------------------
  // operand read decode
  // ----------------------------------------------------------------
  wire crf_opnd_t   rsel = rd_req_in.sel;
  wire logic [31:0] opnd_val =
    (rsel == OPD_DATA0)     ? {16'h0000, d0} :
    (rsel == OPD_DATA1)     ? {16'h0000, d1} :
    (rsel == OPD_DATA2)     ? {16'h0000, d2} :
    (rsel == OPD_DATA3)     ? {16'h0000, d3} :
    (rsel == OPD_D0_LO)     ? {24'h00_0000, d0[7:0]} :
    (rsel == OPD_D0_HI)     ? {24'h00_0000, d0[15:8]} :
    (rsel == OPD_D1_LO)     ? {24'h00_0000, d1[7:0]} :
    (rsel == OPD_D1_HI)     ? {24'h00_0000, d1[15:8]} :
    (rsel == OPD_PAIR_LOW)  ? {d2, d0} :
    (rsel == OPD_PAIR_HIGH) ? {d3, d1} :
    (rsel == OPD_ADDR0)     ? {16'h0000, a0} :
    (rsel == OPD_ADDR1)     ? {16'h0000, a1} :
    (rsel == OPD_ADDR_PAIR) ? {a1, a0} :
    (rsel == OPD_FRAME)     ? {16'h0000, fb} :
    (rsel == OPD_STATIC)    ? {16'h0000, static_r} :
                              {16'h0000, stack_act};
  assign rd_data_nxt = rd_req_in.valid ? opnd_val : rd_data_r;

  // ----------------------------------------------------------------
  // software read decode
  // ----------------------------------------------------------------
  wire logic [31:0] sw_val =
    (sw_addr_in == IDX_DATA0)  ? {16'h0000, d0} :
    (sw_addr_in == IDX_DATA1)  ? {16'h0000, d1} :
    (sw_addr_in == IDX_DATA2)  ? {16'h0000, d2} :
    (sw_addr_in == IDX_DATA3)  ? {16'h0000, d3} :
    (sw_addr_in == IDX_ADDR0)  ? {16'h0000, a0} :
    (sw_addr_in == IDX_ADDR1)  ? {16'h0000, a1} :
    (sw_addr_in == IDX_FRAME)  ? {16'h0000, fb} :
    (sw_addr_in == IDX_VECTB)  ? {12'h000, vectb_r} :
    (sw_addr_in == IDX_NEXTPC) ? {12'h000, pc_r} :
    (sw_addr_in == IDX_USTACK) ? {16'h0000, ustack_r} :
    (sw_addr_in == IDX_ISTACK) ? {16'h0000, istack_r} :
    (sw_addr_in == IDX_STATIC) ? {16'h0000, static_r} :
    (sw_addr_in == IDX_FLAGS)  ? {21'h00_0000, flags_r} :
                                 32'h0000_0000;               // unmapped
  assign sw_rdata_nxt = sw_rd_in ? sw_val : 32'h0000_0000;

  // ----------------------------------------------------------------
  // alu flag evaluation
  // ----------------------------------------------------------------
  wire logic res_zero = (width_mask(flag_upd_in.width, flag_upd_in.result)
                         == 32'h0000_0000);
  wire logic res_neg  = width_sign(flag_upd_in.width, flag_upd_in.result);

  // ----------------------------------------------------------------
  // next-state: software writes first, exec writes override
  // ----------------------------------------------------------------
  always_comb begin
    data_nxt   = data_r;
    addr_nxt   = addr_r;
    frame_nxt  = frame_r;
    vectb_nxt  = vectb_r;
    pc_nxt     = pc_r;
    ustack_nxt = ustack_r;
    istack_nxt = istack_r;
    static_nxt = static_r;
    flags_nxt  = flags_r;
    // software port, selected bank only
    if (sw_wr_in) begin
      if (sw_addr_in == IDX_DATA0) begin
        data_nxt[bank_sel][0] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_DATA1) begin
        data_nxt[bank_sel][1] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_DATA2) begin
        data_nxt[bank_sel][2] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_DATA3) begin
        data_nxt[bank_sel][3] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_ADDR0) begin
        addr_nxt[bank_sel][0] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_ADDR1) begin
        addr_nxt[bank_sel][1] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_FRAME) begin
        frame_nxt[bank_sel] = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_VECTB) begin
        vectb_nxt = sw_wdata_in[ADR_W-1:0];
      end else if (sw_addr_in == IDX_NEXTPC) begin
        pc_nxt = sw_wdata_in[ADR_W-1:0];
      end else if (sw_addr_in == IDX_USTACK) begin
        ustack_nxt = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_ISTACK) begin
        istack_nxt = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_STATIC) begin
        static_nxt = sw_wdata_in[15:0];
      end else if (sw_addr_in == IDX_FLAGS) begin
        flags_nxt = sw_wdata_in[FLG_W-1:0];
      end
    end
    // exec write-back: banked registers into the selected bank, static and stack unbanked
    if (wb_in.valid) begin
      case (wb_in.sel)
        OPD_DATA0: begin
          data_nxt[bank_sel][0] = wb_in.data[15:0];
        end
        OPD_DATA1: begin
          data_nxt[bank_sel][1] = wb_in.data[15:0];
        end
        OPD_DATA2: begin
          data_nxt[bank_sel][2] = wb_in.data[15:0];
        end
        OPD_DATA3: begin
          data_nxt[bank_sel][3] = wb_in.data[15:0];
        end
        OPD_D0_LO: begin
          data_nxt[bank_sel][0][7:0] = wb_in.data[7:0];
        end
        OPD_D0_HI: begin
          data_nxt[bank_sel][0][15:8] = wb_in.data[7:0];
        end
        OPD_D1_LO: begin
          data_nxt[bank_sel][1][7:0] = wb_in.data[7:0];
        end
        OPD_D1_HI: begin
          data_nxt[bank_sel][1][15:8] = wb_in.data[7:0];
        end
        OPD_PAIR_LOW: begin
          data_nxt[bank_sel][0] = wb_in.data[15:0];
          data_nxt[bank_sel][2] = wb_in.data[31:16];
        end
        OPD_PAIR_HIGH: begin
          data_nxt[bank_sel][1] = wb_in.data[15:0];
          data_nxt[bank_sel][3] = wb_in.data[31:16];
        end
        OPD_ADDR0: begin
          addr_nxt[bank_sel][0] = wb_in.data[15:0];
        end
        OPD_ADDR1: begin
          addr_nxt[bank_sel][1] = wb_in.data[15:0];
        end
        OPD_ADDR_PAIR: begin
          addr_nxt[bank_sel][0] = wb_in.data[15:0];
          addr_nxt[bank_sel][1] = wb_in.data[31:16];
        end
        OPD_FRAME: begin
          frame_nxt[bank_sel] = wb_in.data[15:0];
        end
        OPD_STATIC: begin
          static_nxt = wb_in.data[15:0];
        end
        default: begin
          if (ustk_sel) begin
            ustack_nxt = wb_in.data[15:0];
          end else begin
            istack_nxt = wb_in.data[15:0];
          end
        end
      endcase
    end
    // next instruction address load
    if (pc_ld_in.load) begin
      pc_nxt = pc_ld_in.addr;
    end
    // alu flags beat a software flag write
    if (flag_upd_in.valid) begin
      flags_nxt[FLG_C] = flag_upd_in.carry;
      flags_nxt[FLG_Z] = res_zero;
      flags_nxt[FLG_S] = res_neg;
      flags_nxt[FLG_O] = flag_upd_in.ovf;
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) begin
          data_r[b][i] <= RST_WORD;
        end
        addr_r[b][0] <= RST_WORD;
        addr_r[b][1] <= RST_WORD;
        frame_r[b]   <= RST_WORD;
      end
      vectb_r    <= RST_ADR;
      pc_r       <= RST_ADR;
      ustack_r   <= RST_WORD;
      istack_r   <= RST_WORD;
      static_r   <= RST_WORD;
      flags_r    <= RST_FLAGS;
      sw_rdata_r <= 32'h0000_0000;
      rd_data_r  <= 32'h0000_0000;
    end else begin
      data_r     <= data_nxt;
      addr_r     <= addr_nxt;
      frame_r    <= frame_nxt;
      vectb_r    <= vectb_nxt;
      pc_r       <= pc_nxt;
      ustack_r   <= ustack_nxt;
      istack_r   <= istack_nxt;
      static_r   <= static_nxt;
      flags_r    <= flags_nxt;
      sw_rdata_r <= sw_rdata_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sw_rdata_out   = sw_rdata_r;
  assign rd_data_out    = rd_data_r;
  assign flags_out      = flags_r;
  assign ptrs_out.addr0 = a0;
  assign ptrs_out.addr1 = a1;
  assign ptrs_out.frame = fb;
  assign ptrs_out.stat  = static_r;
  assign ptrs_out.stack = stack_act;
  assign ptrs_out.vectb = vectb_r;
  assign ptrs_out.pc    = pc_r;

endmodule

// ==== testbench/crf_regfile_properties.sv ====
// crf_regfile_props: concurrent checks on the register file ports
// assumes a bind onto crf_regfile, one clock, async active-low reset
`timescale 1ns/1ps
module crf_regfile_props
  import crf_pkg::*;
(
  input wire logic                   mclk_in,
  input wire logic                   rst_b_in,
  input wire logic [4:0]             sw_addr_in,
  input wire logic                   sw_wr_in,
  input wire logic                   sw_rd_in,
  input wire logic [31:0]            sw_rdata_out,
  input wire crf_pkg::crf_rd_req_t   rd_req_in,
  input wire logic [31:0]            rd_data_out,
  input wire crf_pkg::crf_wb_t       wb_in,
  input wire crf_pkg::crf_flag_upd_t flag_upd_in,
  input wire crf_pkg::crf_pc_ld_t    pc_ld_in,
  input wire crf_pkg::crf_ptrs_t     ptrs_out,
  input wire logic [10:0]            flags_out
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  property p_rdata_idle;
    !sw_rd_in |=> sw_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_flag_read;
    sw_rd_in && sw_addr_in == IDX_FLAGS |=> sw_rdata_out == {21'h0, $past(flags_out)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag word read wrong");
  property p_zero_byte;
    flag_upd_in.valid && flag_upd_in.width == WID_BYTE
      |=> flags_out[FLG_Z] == ($past(flag_upd_in.result[7:0]) == 8'h00);
  endproperty
  a_zero_byte: assert property (p_zero_byte) else $error("byte zero flag wrong");
  property p_sign_word;
    flag_upd_in.valid && flag_upd_in.width == WID_WORD
      |=> flags_out[FLG_S] == $past(flag_upd_in.result[15]);
  endproperty
  a_sign_word: assert property (p_sign_word) else $error("word sign flag wrong");
  property p_carry_ovf;
    flag_upd_in.valid |=> flags_out[FLG_C] == $past(flag_upd_in.carry)
      && flags_out[FLG_O] == $past(flag_upd_in.ovf);
  endproperty
  a_carry_ovf: assert property (p_carry_ovf) else $error("carry or overflow wrong");
  property p_pc_load;
    pc_ld_in.load |=> ptrs_out.pc == $past(pc_ld_in.addr);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load lost");
  property p_stack_wb;
    wb_in.valid && wb_in.sel == OPD_STACK && !sw_wr_in
      |=> ptrs_out.stack == $past(wb_in.data[15:0]);
  endproperty
  a_stack_wb: assert property (p_stack_wb) else $error("active stack write lost");
  property p_addr_pair;
    rd_req_in.valid && rd_req_in.sel == OPD_ADDR_PAIR && !wb_in.valid && !sw_wr_in
      |=> rd_data_out == {$past(ptrs_out.addr1), $past(ptrs_out.addr0)};
  endproperty
  a_addr_pair: assert property (p_addr_pair) else $error("address pair read wrong");
  property p_rd_hold;
    !rd_req_in.valid |=> $stable(rd_data_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("operand data moved");

  // main scenarios reached
  c_long_upd: cover property (flag_upd_in.valid && flag_upd_in.width == WID_LONG);
  c_pair_high: cover property (rd_req_in.valid && rd_req_in.sel == OPD_PAIR_HIGH);
  c_bank_one: cover property (flags_out[FLG_B] && wb_in.valid);
endmodule

// ==== testbench/test_cpu_register_file_flags.sv ====
// test_cpu_register_file_flags: self-checking bench with a register model
// assumes crf_pkg, crf_regfile and crf_regfile_props are compiled first
`timescale 1ns/1ps
module test_cpu_register_file_flags;
  import crf_pkg::*;
  logic          mclk_in  = 1'b0;
  logic          rst_b_in = 1'b0;
  logic [4:0]    sw_addr  = 5'h00;
  logic [31:0]   sw_wdata = 32'h0;
  logic          sw_wr    = 1'b0;
  logic          sw_rd    = 1'b0;
  crf_rd_req_t   rd_req   = '0;
  crf_wb_t       wb       = '0;
  crf_flag_upd_t fu       = '0;
  crf_pc_ld_t    pl       = '0;
  logic [31:0]   sw_rdata, rd_data, r, r2;
  crf_ptrs_t     ptrs;
  logic [10:0]   flags;
  logic [15:0]   bk [2][7] = '{default: 16'h0};
  logic [19:0]   gr [7:11] = '{default: 20'h0};
  logic [10:0]   m_flg     = 11'h000;
  int            n_fail = 0, n_checks = 0, cycles = 0, i, j, k;
  integer        seed   = 36;

  crf_regfile dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata),
    .rd_req_in(rd_req), .rd_data_out(rd_data), .wb_in(wb), .flag_upd_in(fu),
    .pc_ld_in(pl), .ptrs_out(ptrs), .flags_out(flags));

  // ------------------------------------------------------------
  // clock, timeout, verdict
  // ------------------------------------------------------------
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // register model
  // ------------------------------------------------------------
  function automatic logic [31:0] opv(input crf_opnd_t s);
    logic [15:0] q [7];
    q = bk[m_flg[FLG_B]];
    case (s)
      OPD_D0_LO:     return {24'h0, q[0][7:0]};
      OPD_D0_HI:     return {24'h0, q[0][15:8]};
      OPD_D1_LO:     return {24'h0, q[1][7:0]};
      OPD_D1_HI:     return {24'h0, q[1][15:8]};
      OPD_PAIR_LOW:  return {q[2], q[0]};
      OPD_PAIR_HIGH: return {q[3], q[1]};
      OPD_ADDR0:     return {16'h0, q[4]};
      OPD_ADDR1:     return {16'h0, q[5]};
      OPD_ADDR_PAIR: return {q[5], q[4]};
      OPD_FRAME:     return {16'h0, q[6]};
      OPD_STATIC:    return {12'h0, gr[11]};
      OPD_STACK:     return {12'h0, gr[m_flg[FLG_U] ? 9 : 10]};
      default:       return {16'h0, q[s]};
    endcase
  endfunction
  task automatic mwb(input crf_opnd_t s, input logic [31:0] d);
    int b;
    b = m_flg[FLG_B];
    case (s)
      OPD_D0_LO:     bk[b][0][7:0] = d[7:0];
      OPD_D0_HI:     bk[b][0][15:8] = d[7:0];
      OPD_D1_LO:     bk[b][1][7:0] = d[7:0];
      OPD_D1_HI:     bk[b][1][15:8] = d[7:0];
      OPD_PAIR_LOW:  {bk[b][2], bk[b][0]} = d;
      OPD_PAIR_HIGH: {bk[b][3], bk[b][1]} = d;
      OPD_ADDR0:     bk[b][4] = d[15:0];
      OPD_ADDR1:     bk[b][5] = d[15:0];
      OPD_ADDR_PAIR: {bk[b][5], bk[b][4]} = d;
      OPD_FRAME:     bk[b][6] = d[15:0];
      OPD_STATIC:    gr[11] = {4'h0, d[15:0]};
      OPD_STACK:     gr[m_flg[FLG_U] ? 9 : 10] = {4'h0, d[15:0]};
      default:       bk[b][s] = d[15:0];
    endcase
  endtask
  function automatic logic [31:0] mread(input logic [4:0] a);
    if (a < 7) return {16'h0, bk[m_flg[FLG_B]][a]};
    if (a < 12) return {12'h0, gr[a]};
    return (a == 12) ? {21'h0, m_flg} : 32'h0;
  endfunction
  function automatic crf_ptrs_t eptr();
    int b;
    b = m_flg[FLG_B];
    return '{addr0: bk[b][4], addr1: bk[b][5], frame: bk[b][6], stat: gr[11][15:0],
             stack: gr[m_flg[FLG_U] ? 9 : 10][15:0], vectb: gr[7], pc: gr[8]};
  endfunction

  // ------------------------------------------------------------
  // bus and execution tasks
  // ------------------------------------------------------------
  task automatic go();
    @(posedge mclk_in);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    rd_req.valid <= 1'b0;
    wb.valid <= 1'b0;
    fu.valid <= 1'b0;
    pl.load <= 1'b0;
    #1;
  endtask
  task automatic state();
    chk(flags, m_flg);
    chk(ptrs, eptr());
  endtask
  task automatic sw(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= wr;
    sw_rd <= !wr;
    go();
    if (!wr) chk(sw_rdata, mread(a));
    else if (a < 7) bk[m_flg[FLG_B]][a] = d[15:0];
    else if (a < 9) gr[a] = d[19:0];
    else if (a < 12) gr[a] = {4'h0, d[15:0]};
    else if (a == 12) m_flg = d[10:0];
    state();
  endtask
  task automatic ex(input int op, input logic [31:0] d, input int sel);
    int m;
    m = (sel == 0) ? 7 : (sel == 1) ? 15 : 31;
    @(posedge mclk_in);
    if (op == 0) rd_req <= '{1'b1, crf_opnd_t'(sel)};
    if (op == 1) wb <= '{1'b1, crf_opnd_t'(sel), d};
    if (op == 2) fu <= '{1'b1, crf_width_t'(sel), d, r2[0], r2[1]};
    if (op == 3) pl <= '{1'b1, d[19:0]};
    go();
    if (op == 0) chk(rd_data, opv(crf_opnd_t'(sel)));
    if (op == 1) mwb(crf_opnd_t'(sel), d);
    if (op == 2) m_flg[5:0] = {r2[1], m_flg[4], d[m], ((d << (31 - m)) == 0), m_flg[1], r2[0]};
    if (op == 3) gr[8] = d[19:0];
    state();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 16; i++) sw(1'b0, i[4:0], 32'h0);
    // flag word writes keep the debug bit clear, as software must
    for (i = 0; i < 14; i++) sw(1'b1, i[4:0], $random(seed) & (i == 12 ? 32'h7cd : 32'hffffffff));
    for (i = 0; i < 14; i++) sw(1'b0, i[4:0], 32'h0);
    repeat (2) begin
      sw(1'b1, IDX_FLAGS, {21'h0, m_flg ^ 11'h010});
      for (i = 0; i < 7; i++) begin
        sw(1'b0, i[4:0], 32'h0);
        sw(1'b1, i[4:0], $random(seed));
      end
    end
    for (k = 0; k < 2; k++) begin
      sw(1'b1, IDX_FLAGS, k ? 32'h090 : 32'h000);
      for (i = 0; i < 16; i++) ex(1, $random(seed), i);
      for (i = 0; i < 16; i++) ex(0, 32'h0, i);
    end
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 4; j++) begin
        k = (i == 0) ? 7 : (i == 1) ? 15 : 31;
        r = (j == 0) ? 32'h0 : (j == 1) ? 32'h1 << k : (j == 2) ? 32'hffffffff << k << 1
          : $random(seed);
        r2 = $random(seed);
        ex(2, r, i);
      end
    end
    repeat (2) ex(3, $random(seed), 0);
    conclude();
  end
endmodule

bind crf_regfile crf_regfile_props u_props (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .sw_addr_in(sw_addr_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
  .sw_rdata_out(sw_rdata_out), .rd_req_in(rd_req_in), .rd_data_out(rd_data_out),
  .wb_in(wb_in), .flag_upd_in(flag_upd_in), .pc_ld_in(pc_ld_in), .ptrs_out(ptrs_out),
  .flags_out(flags_out));
